/* File: lpb_defines.svh */
// Constants for the LED phase-shift bank: register offsets, field layout, timing.
// Assumes inclusion by bare name from the package and the modules.
`ifndef LPB_DEFINES_SVH
`define LPB_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define LPB_ADDR_W 5
`define LPB_DATA_W 13
`define LPB_OFS_CH543 5'h12
`define LPB_OFS_CH876 5'h13
`define LPB_OFS_CH11109 5'h14
`define LPB_RESET_PHASE 12'h000
`define LPB_RESET_RDATA 13'h0000

// ****************************************
// Field layout
// ****************************************
`define LPB_CODE_W 4
`define LPB_FIELD_W 12
`define LPB_UNUSED_BIT 12
`define LPB_CHANNELS 9

// ****************************************
// Phase decode and PWM period
// ****************************************
`define LPB_PERIOD 4096
`define LPB_CNT_W 12
`define LPB_CNT_LAST 12'hfff
`define LPB_CNT_ZERO 12'h000
`define LPB_STEPS 12
`define LPB_CODE_MAX_VALID 4'hb

`endif

/* File: lpb_pkg.sv */
// Types and shared decode for the LED phase-shift bank.
// Assumes lpb_defines.svh is on the include path.
`include "lpb_defines.svh"

package lpb_pkg;

  // ****************************************
  // State of the register and counter block
  // ****************************************
  typedef struct packed {
    logic [`LPB_FIELD_W-1:0] phase543;
    logic [`LPB_FIELD_W-1:0] phase876;
    logic [`LPB_FIELD_W-1:0] phase11109;
    logic [`LPB_CNT_W-1:0] count;
    logic periodStart;
    logic [`LPB_DATA_W-1:0] rdData;
    logic rdValid;
  } lpb_top_state_type;

  // ****************************************
  // State of one channel start generator
  // ****************************************
  typedef struct packed {
    logic start;
  } lpb_chan_state_type;

  // Phase code to count offset, rounded to nearest cycle
  function automatic logic [`LPB_CNT_W-1:0] lpb_phase_offset(input logic [`LPB_CODE_W-1:0] code);
    int unsigned v;
    v = 0;
    if (code <= `LPB_CODE_MAX_VALID) begin
      v = (int'(code) * `LPB_PERIOD + `LPB_STEPS / 2) / `LPB_STEPS;
    end
    return v[`LPB_CNT_W-1:0];
  endfunction

endpackage

/* File: lpb_chan_start.sv */
// One channel of phase-shifted PWM start generation.
// Assumes the shared period counter and the channel's phase code on the same clock.
`timescale 1ns/10ps
`include "lpb_defines.svh"

module lpb_chan_start import lpb_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Period count and phase setting
  input wire logic [`LPB_CNT_W-1:0] pwmCount,
  input wire logic [`LPB_CODE_W-1:0] phaseCode,
  // Start of on-time
  output logic startPulse
);

  lpb_chan_state_type state_reg;
  lpb_chan_state_type state_next;

  // ****************************************
  // Start pulse the cycle after the count reaches the decoded offset
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.start = (pwmCount == lpb_phase_offset(phaseCode));
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign startPulse = state_reg.start;

  // ****************************************
  // Checks
  // ****************************************
  property p_start_at_offset;
    @(posedge mclk) disable iff (!nrst)
    startPulse |-> ($past(pwmCount) == lpb_phase_offset($past(phaseCode)));
  endproperty
  a_start_at_offset: assert property (p_start_at_offset) else $error("start not at offset");

  property p_high_codes_zero;
    @(posedge mclk) disable iff (!nrst)
    (phaseCode > `LPB_CODE_MAX_VALID && pwmCount != `LPB_CNT_ZERO) |=> !startPulse;
  endproperty
  a_high_codes_zero: assert property (p_high_codes_zero) else $error("high code not zero phase");

  property p_code3_quarter;
    @(posedge mclk) disable iff (!nrst)
    (phaseCode == 4'h3 && pwmCount == 12'h0400) |=> startPulse;
  endproperty
  a_code3_quarter: assert property (p_code3_quarter) else $error("90 degree start missing");

  property p_code1_step;
    @(posedge mclk) disable iff (!nrst)
    (phaseCode == 4'h1 && pwmCount == 12'h0155) |=> startPulse;
  endproperty
  a_code1_step: assert property (p_code1_step) else $error("30 degree start missing");

endmodule

/* File: lpb_phase_bank.sv */
// Phase-shift register bank and period counter for LED channels 3 to 11.
// Assumes a register port driven by the serial front end on the same clock.
`timescale 1ns/10ps
`include "lpb_defines.svh"

module lpb_phase_bank import lpb_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [`LPB_ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [`LPB_DATA_W-1:0] regWrData,
  input wire logic regRdEn,
  output logic [`LPB_DATA_W-1:0] regRdData,
  output logic regRdValid,
  // PWM timing
  output logic [`LPB_CNT_W-1:0] pwmCount,
  output logic periodStart,
  output logic [`LPB_CHANNELS-1:0] chanStart
);

  lpb_top_state_type state_reg;
  lpb_top_state_type state_next;
  logic [`LPB_CHANNELS*`LPB_CODE_W-1:0] allCodes;

  // ****************************************
  // Register writes, reads and period count
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.rdValid = regRdEn;
    // Period counter wraps after the last count
    if (state_reg.count == `LPB_CNT_LAST) begin
      state_next.count = `LPB_CNT_ZERO;
    end else begin
      state_next.count = state_reg.count + 1'b1;
    end
    state_next.periodStart = (state_next.count == `LPB_CNT_ZERO);
    // Writes keep the code fields, bit 12 dropped
    if (regWrEn) begin
      case (regAddr)
        `LPB_OFS_CH543: begin
          state_next.phase543 = regWrData[`LPB_FIELD_W-1:0];
        end
        `LPB_OFS_CH876: begin
          state_next.phase876 = regWrData[`LPB_FIELD_W-1:0];
        end
        `LPB_OFS_CH11109: begin
          state_next.phase11109 = regWrData[`LPB_FIELD_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Read data; unmapped offsets read zero
    if (regRdEn) begin
      case (regAddr)
        `LPB_OFS_CH543: begin
          state_next.rdData = {1'b0, state_reg.phase543};
        end
        `LPB_OFS_CH876: begin
          state_next.rdData = {1'b0, state_reg.phase876};
        end
        `LPB_OFS_CH11109: begin
          state_next.rdData = {1'b0, state_reg.phase11109};
        end
        default: begin
          state_next.rdData = `LPB_RESET_RDATA;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg.phase543 <= `LPB_RESET_PHASE;
      state_reg.phase876 <= `LPB_RESET_PHASE;
      state_reg.phase11109 <= `LPB_RESET_PHASE;
      state_reg.count <= `LPB_CNT_ZERO;
      state_reg.periodStart <= 1'b0;
      state_reg.rdData <= `LPB_RESET_RDATA;
      state_reg.rdValid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign regRdData = state_reg.rdData;
  assign regRdValid = state_reg.rdValid;
  assign pwmCount = state_reg.count;
  assign periodStart = state_reg.periodStart;

  // ****************************************
  // Channel start generators, ch3 in the low nibble
  // ****************************************
  assign allCodes = {state_reg.phase11109, state_reg.phase876, state_reg.phase543};

  for (genvar ch = 0; ch < `LPB_CHANNELS; ch++) begin : g_chan
    lpb_chan_start u_chan (
      .mclk(mclk),
      .nrst(nrst),
      .pwmCount(state_reg.count),
      .phaseCode(allCodes[ch*`LPB_CODE_W +: `LPB_CODE_W]),
      .startPulse(chanStart[ch])
    );
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_wr_ch876;
    (regWrEn && regAddr == `LPB_OFS_CH876) |=> (state_reg.phase876 == $past(regWrData[`LPB_FIELD_W-1:0]));
  endproperty
  a_wr_ch876: assert property (p_wr_ch876) else $error("ch6-8 write lost");

  property p_wr_ch11109;
    (regWrEn && regAddr == `LPB_OFS_CH11109) |=> (state_reg.phase11109 == $past(regWrData[`LPB_FIELD_W-1:0]));
  endproperty
  a_wr_ch11109: assert property (p_wr_ch11109) else $error("ch9-11 write lost");

  property p_wr_ch543;
    (regWrEn && regAddr == `LPB_OFS_CH543) |=> (state_reg.phase543 == $past(regWrData[`LPB_FIELD_W-1:0]));
  endproperty
  a_wr_ch543: assert property (p_wr_ch543) else $error("ch3-5 write lost");

  property p_readback;
    (regWrEn && regAddr == `LPB_OFS_CH876) ##1 (regRdEn && regAddr == `LPB_OFS_CH876 && !regWrEn)
      |=> (regRdValid && regRdData == {1'b0, $past(regWrData[`LPB_FIELD_W-1:0], 2)});
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs from write");

  property p_bit12_zero;
    regRdValid |-> !regRdData[`LPB_UNUSED_BIT];
  endproperty
  a_bit12_zero: assert property (p_bit12_zero) else $error("unused bit reads one");

  property p_period_wrap;
    (pwmCount == `LPB_CNT_LAST) |=> (pwmCount == `LPB_CNT_ZERO && periodStart);
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("period wrap wrong");

  property p_count_steps;
    (pwmCount != `LPB_CNT_LAST) |=> (pwmCount == $past(pwmCount) + 1'b1 && !periodStart);
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("count did not step");

  property p_ch6_field;
    (regWrEn && regAddr == `LPB_OFS_CH876 && regWrData[3:0] == 4'h6 && pwmCount == 12'h07fe)
      |=> ##2 chanStart[3];
  endproperty
  a_ch6_field: assert property (p_ch6_field) else $error("ch6 180 degree start missing");

  property p_rd_valid;
    regRdEn |=> regRdValid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

  property p_rd_idle;
    !regRdEn |=> (!regRdValid && $stable(regRdData));
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data moved without a read");

  property p_rd_ch543;
    (regRdEn && regAddr == `LPB_OFS_CH543) |=> (regRdData == {1'b0, $past(state_reg.phase543)});
  endproperty
  a_rd_ch543: assert property (p_rd_ch543) else $error("ch3-5 read wrong");

  property p_rd_ch876;
    (regRdEn && regAddr == `LPB_OFS_CH876) |=> (regRdData == {1'b0, $past(state_reg.phase876)});
  endproperty
  a_rd_ch876: assert property (p_rd_ch876) else $error("ch6-8 read wrong");

  property p_rd_ch11109;
    (regRdEn && regAddr == `LPB_OFS_CH11109) |=> (regRdData == {1'b0, $past(state_reg.phase11109)});
  endproperty
  a_rd_ch11109: assert property (p_rd_ch11109) else $error("ch9-11 read wrong");

  property p_rd_unmapped;
    (regRdEn && regAddr != `LPB_OFS_CH543 && regAddr != `LPB_OFS_CH876 && regAddr != `LPB_OFS_CH11109)
      |=> (regRdData == `LPB_RESET_RDATA);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_wr_unmapped;
    (regWrEn && regAddr != `LPB_OFS_CH543 && regAddr != `LPB_OFS_CH876 && regAddr != `LPB_OFS_CH11109)
      |=> ($stable(state_reg.phase543) && $stable(state_reg.phase876)
        && $stable(state_reg.phase11109));
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write changed a field");

  property p_fields_hold;
    !regWrEn |=> ($stable(state_reg.phase543) && $stable(state_reg.phase876)
      && $stable(state_reg.phase11109));
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("field changed without a write");

  property p_period_start_zero;
    periodStart |-> (pwmCount == `LPB_CNT_ZERO);
  endproperty
  a_period_start_zero: assert property (p_period_start_zero) else $error("period start off zero");

  property p_ch4_field;
    (state_reg.phase543[7:4] == 4'h2 && pwmCount == 12'h02ab) |=> chanStart[1];
  endproperty
  a_ch4_field: assert property (p_ch4_field) else $error("ch4 60 degree start missing");

  property p_ch5_field;
    (state_reg.phase543[11:8] == 4'hc && pwmCount == `LPB_CNT_ZERO) |=> chanStart[2];
  endproperty
  a_ch5_field: assert property (p_ch5_field) else $error("ch5 high code start missing");

  property p_ch7_field;
    (state_reg.phase876[7:4] == 4'he && pwmCount == `LPB_CNT_ZERO) |=> chanStart[4];
  endproperty
  a_ch7_field: assert property (p_ch7_field) else $error("ch7 high code start missing");

  property p_ch9_field;
    (state_reg.phase11109[3:0] == 4'h3 && pwmCount == 12'h0400) |=> chanStart[6];
  endproperty
  a_ch9_field: assert property (p_ch9_field) else $error("ch9 90 degree start missing");

  property p_ch11_field;
    (state_reg.phase11109[11:8] == 4'h6 && pwmCount == 12'h0800) |=> chanStart[8];
  endproperty
  a_ch11_field: assert property (p_ch11_field) else $error("ch11 180 degree start missing");

endmodule

/* File: lpb_mcu_model.sv */
// Controller model on the far side of the phase bank's register port.
// Assumes the bank samples strobes and address on the rising mclk edge.
`timescale 1ns/10ps
`include "lpb_defines.svh"

module lpb_mcu_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [`LPB_ADDR_W-1:0] regAddr,
  output logic regWrEn,
  output logic [`LPB_DATA_W-1:0] regWrData,
  output logic regRdEn,
  input wire logic [`LPB_DATA_W-1:0] regRdData,
  input wire logic regRdValid
);
  // Idle bus at time zero
  initial begin
    regAddr = 5'h1f;
    regWrEn = 1'b0;
    regWrData = 13'h1fff;
    regRdEn = 1'b0;
  end

  // One-cycle write; the released bus shows the inverse so stale values never pass
  task automatic wr(input logic [4:0] a, input logic [12:0] d);
    @(posedge mclk);
    #2;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge mclk);
    #2;
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask

  // One-cycle read; answer taken the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [12:0] d, output logic v);
    @(posedge mclk);
    #2;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge mclk);
    #2;
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
    v = regRdValid;
  endtask

  // Write, then read the same offset in the very next cycle
  task automatic wrrd(input logic [4:0] a, input logic [12:0] d, output logic [12:0] q, output logic v);
    @(posedge mclk);
    #2;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge mclk);
    #2;
    regWrEn = 1'b0;
    regRdEn = 1'b1;
    @(posedge mclk);
    #2;
    regRdEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    q = regRdData;
    v = regRdValid;
  endtask
endmodule

/* File: lpb_phase_bank_test.sv */
// Self-checking bench for the phase bank: register access and start timing.
// Assumes the controller model drives the register port.
`timescale 1ns/10ps
`include "lpb_defines.svh"

module lpb_phase_bank_test;
  logic mclk;
  logic nrst;
  logic [4:0] regAddr;
  logic regWrEn;
  logic [12:0] regWrData;
  logic regRdEn;
  logic [12:0] regRdData;
  logic regRdValid;
  logic [11:0] pwmCount;
  logic periodStart;
  logic [8:0] chanStart;
  int numErrors = 0;
  int nTests = 0;
  int cycles = 0;

  lpb_phase_bank i_lpb_phase_bank (.mclk(mclk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .pwmCount(pwmCount), .periodStart(periodStart), .chanStart(chanStart));
  lpb_mcu_model i_lpb_mcu_model (.mclk(mclk), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));

  // 50 ns clock
  always #25 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      numErrors++;
      summarize();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Start offset of a code, rounded half up
  function automatic logic [11:0] offs(input logic [3:0] c);
    return (c <= 4'hb) ? 12'((int'(c) * 4096 + 6) / 12) : 12'h000;
  endfunction

  // Read one register and compare
  task automatic rdchk(input logic [4:0] a, input logic [12:0] exp);
    logic [12:0] d;
    logic v;
    i_lpb_mcu_model.rd(a, d, v);
    chk("regRdValid", 13'h0001, {12'h000, v});
    chk("regRdData", exp, d);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    for (int r = 0; r < 3; r++) rdchk(5'(5'h12 + r), 13'h0000);
    $display("test_reset done");
  endtask

  // Bit 12 set on two writes, writes one idle cycle apart, unmapped offset
  task automatic test_regs();
    i_lpb_mcu_model.wr(5'h12, 13'h1abc);
    i_lpb_mcu_model.wr(5'h13, 13'h0321);
    i_lpb_mcu_model.wr(5'h14, 13'h1e5d);
    i_lpb_mcu_model.wr(5'h15, 13'h0777);
    rdchk(5'h12, 13'h0abc);
    rdchk(5'h13, 13'h0321);
    rdchk(5'h14, 13'h0e5d);
    rdchk(5'h15, 13'h0000);
    $display("test_regs done");
  endtask

  // Program nine codes, then watch one whole period
  task automatic test_phase(input logic [3:0] c [9]);
    int hits [9];
    int n;
    for (int r = 0; r < 3; r++) i_lpb_mcu_model.wr(5'(5'h12 + r), {1'b0, c[3*r+2], c[3*r+1], c[3*r]});
    n = 0;
    while (periodStart !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      #2;
      n++;
    end
    for (int t = 0; t < 4096; t++) begin
      chk("periodStart", {12'h000, pwmCount == 12'h000}, {12'h000, periodStart});
      chk("pwmCount", 13'(t), {1'b0, pwmCount});
      for (int k = 0; k < 9; k++) begin
        if (chanStart[k] === 1'b1) begin
          hits[k]++;
          chk("chanStart", {1'b0, offs(c[k]) + 12'h001}, {1'b0, pwmCount});
        end
      end
      @(posedge mclk);
      #2;
    end
    for (int k = 0; k < 9; k++) chk("startCount", 13'h0001, 13'(hits[k]));
    $display("test_phase done");
  endtask

  // Back-to-back write and read, then a write landing just before a start
  task automatic test_timing();
    logic [12:0] d;
    logic v;
    i_lpb_mcu_model.wrrd(5'h13, 13'h1bc5, d, v);
    chk("wrrdValid", 13'h0001, {12'h000, v});
    chk("wrrdData", 13'h0bc5, d);
    while (pwmCount !== 12'h7fd) begin
      @(posedge mclk);
      #2;
    end
    i_lpb_mcu_model.wr(5'h13, 13'h0006);
    @(posedge mclk);
    #2;
    chk("chanStartEarly", 13'h0000, {4'h0, chanStart});
    @(posedge mclk);
    #2;
    chk("pwmCount", 13'h0801, {1'b0, pwmCount});
    chk("chanStart3", 13'h0001, {12'h000, chanStart[3]});
    $display("test_timing done");
  endtask

  // Reset in mid-run clears the fields and restarts the count
  task automatic test_midreset();
    i_lpb_mcu_model.wr(5'h14, 13'h0abc);
    @(posedge mclk);
    #2;
    nrst = 1'b0;
    @(posedge mclk);
    #2;
    chk("pwmCountRst", 13'h0000, {1'b0, pwmCount});
    chk("chanStartRst", 13'h0000, {4'h0, chanStart});
    nrst = 1'b1;
    @(posedge mclk);
    #2;
    chk("pwmCountRel", 13'h0001, {1'b0, pwmCount});
    chk("periodStartRel", 13'h0000, {12'h000, periodStart});
    chk("chanStartRel", 13'h01ff, {4'h0, chanStart});
    rdchk(5'h14, 13'h0000);
    $display("test_midreset done");
  endtask

  // Closing report
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence; code 0xF never written
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    repeat (12) @(posedge mclk);
    #2;
    nrst = 1'b1;
    test_reset();
    test_regs();
    test_phase('{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9});
    test_phase('{4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'h0, 4'h3, 4'hb, 4'h6});
    test_timing();
    test_midreset();
    summarize();
  end
endmodule
